// File: ihd_top.v
// Inrush harmonic detector top: three phases, general flag, on/off event pulses.
// Assumes Fourier magnitudes from an upstream analyser, synchronous to clk.
//
// Function
// RULE1: Flag phase inrush when second-harmonic ratio exceeds ratio setting 5-50%, default 15.
// RULE2: Suppress phase flag unless fundamental exceeds sensitivity threshold.
// RULE3: Sensitivity setting 20-100% of CT nominal, step 1, default 30.
// RULE4: Three phases evaluated independently, each with its own flag.
// RULE5: General flag is set when any phase flag is set.
// RULE6: Blocking input disables detection and clears all outputs; the off event still pulses once when a standing flag is cleared.
// RULE7: Report restraint event on when general flag rises, off when it falls.
// RULE8: Operation enable off, the default, keeps all outputs deasserted; switching it off under a standing flag still pulses the off event once.
`timescale 1ns/1ps
`include "ihd_defs.vh"
module ihd_top #(
  parameter MAG_W = `IHD_MAG_W,
  parameter PCT_W = `IHD_PCT_W
) (
  input  wire                 clk,
  input  wire                 rst,
  input  wire [3*MAG_W-1:0]   fund_mag,
  input  wire [3*MAG_W-1:0]   harm2_mag,
  input  wire [MAG_W-1:0]     nominal_mag,
  input  wire                 operation_enable,
  input  wire                 detect_block_in,
  input  wire                 settings_load,
  input  wire [PCT_W-1:0]     harmonic_ratio_setting,
  input  wire [PCT_W-1:0]     fundamental_sensitivity_setting,
  output reg                  inrush_phase1_out,
  output reg                  inrush_phase2_out,
  output reg                  inrush_phase3_out,
  output reg                  inrush_any_out,
  output reg                  restraint_event_on,
  output reg                  restraint_event_off
);
  // Live settings, loaded together by the settings strobe.
  reg  [PCT_W-1:0] ratio_pct;
  reg  [PCT_W-1:0] sens_pct;
  reg              enable;
  // Clamped copies of the incoming settings, ready to be loaded.
  reg  [PCT_W-1:0] next_ratio;
  reg  [PCT_W-1:0] next_sens;
  // Per-phase decisions, before and after the block and enable gate.
  wire [2:0]       phase_detect;
  wire             detect_allowed;
  wire [2:0]       gated;
  wire             any_next;
  // Next values of the two event pulses.
  reg              next_event_on;
  reg              next_event_off;

  // Clamp the ratio setting into its legal range.
  // A value outside the range is pulled to the nearest limit rather than refused,
  // so a careless setting still leaves a working restraint behind it.
  always @* begin
    next_ratio = harmonic_ratio_setting;
    if (harmonic_ratio_setting < `IHD_RATIO_MIN) begin
      next_ratio = `IHD_RATIO_MIN; // RULE1
    end
    if (harmonic_ratio_setting > `IHD_RATIO_MAX) begin
      next_ratio = `IHD_RATIO_MAX; // RULE1
    end
  end

  // Clamp the fundamental sensitivity setting into its legal range.
  // The floor matters most: without it, small noisy currents whose harmonic
  // content is mostly measurement error could raise a flag.
  always @* begin
    next_sens = fundamental_sensitivity_setting;
    if (fundamental_sensitivity_setting < `IHD_SENS_MIN) begin
      next_sens = `IHD_SENS_MIN; // RULE3
    end
    if (fundamental_sensitivity_setting > `IHD_SENS_MAX) begin
      next_sens = `IHD_SENS_MAX; // RULE3
    end
  end

  // Ratio setting register: default after reset, new value on a load strobe.
  always @(posedge clk) begin
    if (rst) begin
      ratio_pct <= `IHD_RATIO_DEF; // RULE1
    end else if (settings_load) begin
      ratio_pct <= next_ratio; // RULE1
    end
  end

  // Sensitivity setting register: loaded in the same way as the ratio.
  always @(posedge clk) begin
    if (rst) begin
      sens_pct <= `IHD_SENS_DEF; // RULE3
    end else if (settings_load) begin
      sens_pct <= next_sens; // RULE3
    end
  end

  // Operation enable: off after reset, so the detector stays silent until it
  // is switched on together with the other settings.
  always @(posedge clk) begin
    if (rst) begin
      enable <= 1'b0; // RULE8
    end else if (settings_load) begin
      enable <= operation_enable; // RULE8
    end
  end

  // Phase 1 detector. The phases share the clock, the reset, the settings and the nominal magnitude and nothing else, so one
  // phase can never raise or hold the flag of another.
  ihd_phase #(
    .MAG_W (MAG_W),
    .PCT_W (PCT_W)
  ) phase1_det (
    .clk         (clk),
    .rst         (rst),
    .fund_mag    (fund_mag[MAG_W-1:0]),
    .harm2_mag   (harm2_mag[MAG_W-1:0]),
    .nominal_mag (nominal_mag),
    .ratio_pct   (ratio_pct),
    .sens_pct    (sens_pct),
    .detect      (phase_detect[0])
  ); // RULE4

  // Phase 2 detector.
  ihd_phase #(
    .MAG_W (MAG_W),
    .PCT_W (PCT_W)
  ) phase2_det (
    .clk         (clk),
    .rst         (rst),
    .fund_mag    (fund_mag[2*MAG_W-1:MAG_W]),
    .harm2_mag   (harm2_mag[2*MAG_W-1:MAG_W]),
    .nominal_mag (nominal_mag),
    .ratio_pct   (ratio_pct),
    .sens_pct    (sens_pct),
    .detect      (phase_detect[1])
  ); // RULE4

  // Phase 3 detector.
  ihd_phase #(
    .MAG_W (MAG_W),
    .PCT_W (PCT_W)
  ) phase3_det (
    .clk         (clk),
    .rst         (rst),
    .fund_mag    (fund_mag[3*MAG_W-1:2*MAG_W]),
    .harm2_mag   (harm2_mag[3*MAG_W-1:2*MAG_W]),
    .nominal_mag (nominal_mag),
    .ratio_pct   (ratio_pct),
    .sens_pct    (sens_pct),
    .detect      (phase_detect[2])
  ); // RULE4

  // Block and enable gate every flag ahead of the output flops.
  // Gating here rather than inside the phase detectors clears all flag outputs at
  // the very next edge, whatever the phase registers hold at that moment.
  // The phase registers keep running meanwhile, so release is just as quick.
  assign detect_allowed = enable && !detect_block_in; // RULE6 RULE8
  assign gated          = detect_allowed ? phase_detect : 3'h0; // RULE6 RULE8

  // The general flag is the OR of the gated phase flags, so it can never
  // disagree with the phase outputs that are loaded at the same edge.
  assign any_next = |gated; // RULE5

  // Edge detection of the general flag against its registered copy.
  // That copy is cleared in reset, the idle level of the flag, so no false
  // event follows the release of reset.
  always @* begin
    next_event_on  = any_next && !inrush_any_out; // RULE7
    next_event_off = !any_next && inrush_any_out; // RULE7
  end

  // Phase 1 flag.
  always @(posedge clk) begin
    if (rst) begin
      inrush_phase1_out <= 1'b0;
    end else begin
      inrush_phase1_out <= gated[0]; // RULE4
    end
  end

  // Phase 2 flag.
  always @(posedge clk) begin
    if (rst) begin
      inrush_phase2_out <= 1'b0;
    end else begin
      inrush_phase2_out <= gated[1]; // RULE4
    end
  end

  // Phase 3 flag.
  always @(posedge clk) begin
    if (rst) begin
      inrush_phase3_out <= 1'b0;
    end else begin
      inrush_phase3_out <= gated[2]; // RULE4
    end
  end

  // General flag, loaded at the same edge as the phase flags.
  always @(posedge clk) begin
    if (rst) begin
      inrush_any_out <= 1'b0;
    end else begin
      inrush_any_out <= any_next; // RULE5
    end
  end

  // On event: a one-cycle pulse in the cycle in which the general flag rises.
  // Downstream logic that only wants changes can count these without polling.
  always @(posedge clk) begin
    if (rst) begin
      restraint_event_on <= 1'b0;
    end else begin
      restraint_event_on <= next_event_on; // RULE7
    end
  end

  // Off event: a one-cycle pulse in the cycle in which the general flag falls.
  // A block or a disable that clears a standing flag reports this as well.
  always @(posedge clk) begin
    if (rst) begin
      restraint_event_off <= 1'b0;
    end else begin
      restraint_event_off <= next_event_off; // RULE7
    end
  end
endmodule // ihd_top

// File: ihd_defs.vh
// Constants for the inrush harmonic detector: setting ranges, defaults and widths.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef IHD_DEFS_VH
`define IHD_DEFS_VH
`define IHD_MAG_W        16
`define IHD_PCT_W        7
`define IHD_RATIO_MIN    7'h05
`define IHD_RATIO_MAX    7'h32
`define IHD_RATIO_DEF    7'h0f
`define IHD_SENS_MIN     7'h14
`define IHD_SENS_MAX     7'h64
`define IHD_SENS_DEF     7'h1e
`define IHD_PCT_FULL     7'h64
`endif

// File: ihd_phase.v
// One phase of the inrush detector: ratio and sensitivity comparisons.
// Assumes magnitudes are unsigned and settings are already clamped to range.
`timescale 1ns/1ps
`include "ihd_defs.vh"
module ihd_phase #(
  parameter MAG_W = `IHD_MAG_W,
  parameter PCT_W = `IHD_PCT_W
) (
  input  wire               clk,
  input  wire               rst,
  input  wire [MAG_W-1:0]   fund_mag,
  input  wire [MAG_W-1:0]   harm2_mag,
  input  wire [MAG_W-1:0]   nominal_mag,
  input  wire [PCT_W-1:0]   ratio_pct,
  input  wire [PCT_W-1:0]   sens_pct,
  output reg                detect
);
  localparam PW = MAG_W + PCT_W;
  localparam [PCT_W-1:0] PCT_FULL = `IHD_PCT_FULL;
  wire [PW-1:0] harm_scaled;
  wire [PW-1:0] fund_scaled;
  wire [PW-1:0] fund_pct;
  wire [PW-1:0] nom_scaled;
  // Cross-multiplied comparisons avoid a divider: h2*100 > f*ratio.
  // Both operands are widened to the product width first, so no bit is lost.
  assign harm_scaled = {{PCT_W{1'b0}}, harm2_mag} * {{MAG_W{1'b0}}, PCT_FULL};
  assign fund_scaled = {{PCT_W{1'b0}}, fund_mag} * {{MAG_W{1'b0}}, ratio_pct};
  assign fund_pct    = {{PCT_W{1'b0}}, fund_mag} * {{MAG_W{1'b0}}, PCT_FULL};
  assign nom_scaled  = {{PCT_W{1'b0}}, nominal_mag} * {{MAG_W{1'b0}}, sens_pct};
  // Registered decision for this phase.
  always @(posedge clk) begin
    if (rst) begin
      detect <= 1'b0;
    end else begin
      detect <= (harm_scaled > fund_scaled) && (fund_pct > nom_scaled); // RULE1 RULE2
    end
  end
endmodule // ihd_phase

// File: ihd_src.sv
// Analyser and blocking logic model that feeds the detector.
// Assumes the bench changes its request just after the rising edge.
`timescale 1ns/1ps
module ihd_src (input wire clk, input wire [96:0] req, output logic [47:0] fund_mag = 0,
  output logic [47:0] harm2_mag = 0, output logic detect_block_in = 0);
  // Fresh magnitudes and the block level follow a request by one cycle.
  always @(posedge clk) {fund_mag, harm2_mag, detect_block_in} <= req;
endmodule // ihd_src

// File: ihd_top_properties.sv
// Checker on the detector top ports: flags, events and blocking.
// Assumes it is bound to every instance of the top.
`timescale 1ns/1ps
module ihd_props (input wire clk, rst, detect_block_in, inrush_phase1_out, inrush_phase2_out,
  inrush_phase3_out, inrush_any_out, restraint_event_on, restraint_event_off);
  wire [3:0] f = {inrush_phase3_out, inrush_phase2_out, inrush_phase1_out, inrush_any_out};
  wire on = restraint_event_on, of = restraint_event_off;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_any; f[0] == |f[3:1]; endproperty
  a_any: assert property (p_any) else $error("any");
  property p_on; on == (f[0] && !$past(f[0])); endproperty
  a_on: assert property (p_on) else $error("on");
  property p_of; of == (!f[0] && $past(f[0])); endproperty
  a_of: assert property (p_of) else $error("off");
  property p_blk; $past(detect_block_in) |-> f == 4'h0; endproperty
  a_blk: assert property (p_blk) else $error("blk");
  property p_onp; on |=> !on; endproperty
  a_onp: assert property (p_onp) else $error("onp");
  property p_bev; detect_block_in |=> !on; endproperty
  a_bev: assert property (p_bev) else $error("bev");
endmodule // ihd_props
bind ihd_top ihd_props ihd_props_i (
  .clk                 (clk),
  .rst                 (rst),
  .detect_block_in     (detect_block_in),
  .inrush_phase1_out   (inrush_phase1_out),
  .inrush_phase2_out   (inrush_phase2_out),
  .inrush_phase3_out   (inrush_phase3_out),
  .inrush_any_out      (inrush_any_out),
  .restraint_event_on  (restraint_event_on),
  .restraint_event_off (restraint_event_off)
);

// File: tb_top.sv
// Bench for the detector: enable off, detection and blocking.
// Assumes the analyser model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, operation_enable = 0, settings_load = 0;
  logic [6:0] harmonic_ratio_setting = 7'h0f, fundamental_sensitivity_setting = 7'h1e;
  logic [15:0] nominal_mag = 16'h03e8;
  logic [96:0] req = 0;
  wire [47:0] fund_mag, harm2_mag;
  wire detect_block_in, inrush_phase1_out, inrush_phase2_out, inrush_phase3_out;
  wire inrush_any_out, restraint_event_on, restraint_event_off;
  wire [5:0] fl = {inrush_phase3_out, inrush_phase2_out, inrush_phase1_out, inrush_any_out,
    restraint_event_on, restraint_event_off};
  int error_cnt = 0, n_tests = 0;
  // Free-running 200 MHz clock.
  initial forever #2.5 clk = ~clk;
  ihd_src ihd_src_i (
    .clk             (clk),
    .req             (req),
    .fund_mag        (fund_mag),
    .harm2_mag       (harm2_mag),
    .detect_block_in (detect_block_in)
  );
  ihd_top ihd_top_i (
    .clk                             (clk),
    .rst                             (rst),
    .fund_mag                        (fund_mag),
    .harm2_mag                       (harm2_mag),
    .nominal_mag                     (nominal_mag),
    .operation_enable                (operation_enable),
    .detect_block_in                 (detect_block_in),
    .settings_load                   (settings_load),
    .harmonic_ratio_setting          (harmonic_ratio_setting),
    .fundamental_sensitivity_setting (fundamental_sensitivity_setting),
    .inrush_phase1_out               (inrush_phase1_out),
    .inrush_phase2_out               (inrush_phase2_out),
    .inrush_phase3_out               (inrush_phase3_out),
    .inrush_any_out                  (inrush_any_out),
    .restraint_event_on              (restraint_event_on),
    .restraint_event_off             (restraint_event_off)
  );
  // Waits n edges and compares flags and event pulses: {L3, L2, L1, any, on, off}.
  task chk(input int n, input logic [5:0] e);
    repeat (n) @(posedge clk);
    #1 n_tests++;
    if (fl !== e) $display("BAD %0t %h %h", $time, fl, e);
    error_cnt += (fl !== e);
  endtask
  // Loads settings with a one-cycle strobe and new magnitudes alongside.
  task load(input logic [6:0] r, input logic [6:0] s, input logic en, input logic [96:0] q);
    {harmonic_ratio_setting, fundamental_sensitivity_setting} = {r, s};
    {operation_enable, settings_load, req} = {en, 1'b1, q};
    @(posedge clk) #1 settings_load = 0;
  endtask
  // Phase 1 just over the ratio, phase 2 on it, phase 3 on the sensitivity.
  task t_det;
    req = {48'h012c_0190_0190, 48'h00c8_003c_003d, 1'b0};
    chk(4, 6'h00);
    load(7'h0f, 7'h1e, 1'b1, req);
    chk(1, 6'h0e);
    chk(1, 6'h0c);
  endtask
  // Blocking on top of a standing detection, then its release.
  task t_blk;
    req[0] = 1'b1;
    chk(2, 6'h01);
    chk(1, 6'h00);
    req[0] = 1'b0;
    chk(2, 6'h0e);
    chk(1, 6'h0c);
  endtask
  // Phase 3 alone, then phase 2 alone, each just over the ratio.
  task t_phs;
    req = {48'h0190_0190_0190, 48'h003d_003c_003c, 1'b0};
    chk(3, 6'h24);
    req = {48'h0190_0190_0190, 48'h003c_003d_003c, 1'b0};
    chk(3, 6'h14);
  endtask
  // Out-of-range settings land on the limits: 50 and 20, then 5 and 100.
  task t_clamp;
    load(7'h7f, 7'h00, 1'b1, {48'h00c8_0190_0190, 48'h0065_00c8_00c9, 1'b0});
    chk(2, 6'h0c);
    load(7'h00, 7'h7f, 1'b1, {48'h03e8_03e9_03e9, 48'h0064_0032_0033, 1'b0});
    chk(2, 6'h0c);
  endtask
  // Switching operation off clears a standing detection.
  task t_off;
    load(7'h0f, 7'h1e, 1'b0, req);
    chk(1, 6'h01);
    chk(2, 6'h00);
  endtask
  task give_verdict;
    $display("errors %0d of %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Holds reset for 16 cycles, then runs the scenarios.
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    t_det;
    t_blk;
    t_phs;
    t_clamp;
    t_off;
    give_verdict;
  end
endmodule // tb_top
